// ---- rtl/tprt_pkg.sv ----
// Package: constants for the timer power/reset/trigger block
// Assumes: included before all rtl modules; no imports are used
package tprt_pkg;
  // ************************************************************
  // Control register bit positions
  // ************************************************************
  localparam int CTL_ON = 15;
  localparam int CTL_STOP_IDLE = 13;
  localparam int CTL_GATE = 7;
  localparam int CTL_PAIR32 = 3;
  localparam int CTL_SYNC = 2;
  localparam int CTL_SRC_SEL = 1;
  // ************************************************************
  // Register addresses of the plain port (byte addresses)
  // ************************************************************
  localparam logic [5:0] A_CTL_A = 6'h00;
  localparam logic [5:0] A_CNT_A = 6'h04;
  localparam logic [5:0] A_PER_A = 6'h08;
  localparam logic [5:0] A_CTL_B = 6'h0C;
  localparam logic [5:0] A_CNT_B = 6'h10;
  localparam logic [5:0] A_PER_B = 6'h14;
  localparam logic [5:0] A_CNT_C = 6'h18;
  localparam logic [5:0] A_PER_C = 6'h1C;
  localparam logic [5:0] A_IRQ = 6'h20;
  localparam logic [5:0] A_STAT = 6'h24;
  // ************************************************************
  // Reset values and priority limits
  // ************************************************************
  localparam logic [15:0] RST_CTL = 16'h0000;
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [15:0] RST_PER = 16'hFFFF;
  localparam logic [2:0] PRIO_NONE = 3'h0;
  localparam logic [2:0] PRIO_MAX = 3'h7;
  // Power states reported by the power controller
  localparam logic [1:0] PWR_RUN = 2'h0;
  localparam logic [1:0] PWR_IDLE = 2'h1;
  localparam logic [1:0] PWR_SLEEP = 2'h2;
endpackage

// ---- rtl/tprt_sync.sv ----
// Two flip-flop synchroniser for single-bit levels
// Assumes: din is asynchronous to clk; rst is asynchronous active high
`timescale 1ns/1ns
module tprt_sync
(
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic meta;
  // Second stage is the only reader of the first
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// ---- rtl/tprt_async_cnt.sv ----
// Asynchronous counter running on the external pin clock
// Assumes: ext_clk free of the bus clock; controls held stable while running;
// run and snap_req already pass two ext_clk flip-flops
`timescale 1ns/1ns
module tprt_async_cnt #(parameter int W = 16)
(
  input wire logic ext_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [W-1:0] period,
  input wire logic snap_req,
  output logic [W-1:0] count,
  output logic [W-1:0] snap,
  output logic snap_ack,
  output logic match_tgl
);
  // Count, wrap at period and toggle once per match; answer copy requests
  always_ff @(posedge ext_clk or posedge rst)
  begin
    if (rst)
    begin
      count <= '0;
      match_tgl <= 1'b0;
      snap <= '0;
      snap_ack <= 1'b0;
    end
    else
    begin
      if (run)
      begin
        if (count == period)
        begin
          count <= '0;
          match_tgl <= ~match_tgl;
        end
        else
          count <= count + 1'b1;
      end
      // Copy stays frozen until the bus side asks again
      if (snap_req != snap_ack)
      begin
        snap <= count;
        snap_ack <= snap_req;
      end
    end
  end
endmodule

// ---- rtl/tprt_top.sv ----
// Timer power, reset, trigger and pin claim logic: one async-capable
// timer and a pairable timer pair with event trigger.
// Assumes: mclk is the peripheral bus clock, left running by the power
// controller in sleep; ext_clk is the async timer's pin clock.
`timescale 1ns/1ns
module tprt_top
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ext_clk,
  input wire logic por_rst,
  input wire logic wdt_rst,
  input wire logic [1:0] pwr_state,
  input wire logic [2:0] cpu_prio,
  input wire logic pin_b_in,
  input wire logic pin_c_in,
  input wire logic [5:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic [1:0] tb_sel,
  output logic [31:0] time_base,
  output logic adc_trigger,
  output logic wake_req,
  output logic enter_idle,
  output logic irq,
  output logic [2:0] pin_claim
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [15:0] ctl_a;
    logic [15:0] per_a;
    logic [15:0] ctl_b;
    logic [15:0] cnt_b;
    logic [15:0] per_b;
    logic [15:0] cnt_c;
    logic [15:0] per_c;
    logic [2:0] prio_a;
    logic ie_a;
    logic if_a;
    logic if_b;
    logic wake;
    logic idle_req;
    logic trig;
    logic [1:0] tb;
    logic tgl_seen;
    logic [15:0] cnt_a;
    logic snap_req;
    logic clk_b_q;
    logic clk_c_q;
    logic [31:0] rdata;
  } tprt_state_s;

  tprt_state_s st;
  tprt_state_s next_st;
  logic any_rst;
  logic [15:0] snap_a;
  logic snap_ack;
  logic ack_s;
  logic req_ext;
  logic run_ext;
  logic match_tgl;
  logic tgl_sync;
  logic pin_b_s;
  logic pin_c_s;
  logic async_run;
  logic in_sleep;
  logic in_idle;
  logic run_b;
  logic tick_b;
  logic tick_c;
  logic pair;
  logic match16;
  logic match32;
  logic a_event;
  logic wake_ok;

  // Every reset source resets the whole block
  assign any_rst = rst | por_rst | wdt_rst;

  assign in_sleep = (pwr_state == tprt_pkg::PWR_SLEEP);
  assign in_idle = (pwr_state == tprt_pkg::PWR_IDLE);
  // Async timer keeps counting only when on, external and unsynced
  assign async_run = st.ctl_a[tprt_pkg::CTL_ON] & st.ctl_a[tprt_pkg::CTL_SRC_SEL]
    & ~st.ctl_a[tprt_pkg::CTL_SYNC]
    & ~(in_idle & st.ctl_a[tprt_pkg::CTL_STOP_IDLE]);

  // ************************************************************
  // Pin clock domain and crossings
  // ************************************************************
  // Run enable and copy request enter the pin clock through two flops
  tprt_sync u_sync_run (.clk(ext_clk), .rst(any_rst), .din(async_run), .dout(run_ext));
  tprt_sync u_sync_req (.clk(ext_clk), .rst(any_rst), .din(st.snap_req), .dout(req_ext));
  tprt_async_cnt #(.W(16)) u_cnt
  (
    .ext_clk(ext_clk),
    .rst(any_rst),
    .run(run_ext),
    .period(st.per_a),
    .snap_req(req_ext),
    .count(),
    .snap(snap_a),
    .snap_ack(snap_ack),
    .match_tgl(match_tgl)
  );
  tprt_sync u_sync_ack (.clk(mclk), .rst(any_rst), .din(snap_ack), .dout(ack_s));

  tprt_sync u_sync_tgl (.clk(mclk), .rst(any_rst), .din(match_tgl), .dout(tgl_sync));
  tprt_sync u_sync_pb (.clk(mclk), .rst(any_rst), .din(pin_b_in), .dout(pin_b_s));
  tprt_sync u_sync_pc (.clk(mclk), .rst(any_rst), .din(pin_c_in), .dout(pin_c_s));

  // ************************************************************
  // Synchronous timer pair
  // ************************************************************
  // Run enable: halted in sleep and, with stop-in-idle, in idle
  assign run_b = st.ctl_b[tprt_pkg::CTL_ON] & ~in_sleep
    & ~(in_idle & st.ctl_b[tprt_pkg::CTL_STOP_IDLE]);
  assign pair = st.ctl_b[tprt_pkg::CTL_PAIR32];
  // Count tick: pin rising edge, gated bus clock, or bus clock
  always_comb
  begin
    if (st.ctl_b[tprt_pkg::CTL_SRC_SEL])
      tick_b = pin_b_s & ~st.clk_b_q;
    else if (st.ctl_b[tprt_pkg::CTL_GATE])
      tick_b = pin_b_s;
    else
      tick_b = 1'b1;
    if (st.ctl_b[tprt_pkg::CTL_SRC_SEL])
      tick_c = pin_c_s & ~st.clk_c_q;
    else if (st.ctl_b[tprt_pkg::CTL_GATE])
      tick_c = pin_c_s;
    else
      tick_c = 1'b1;
  end
  assign match16 = (st.cnt_b == st.per_b);
  assign match32 = ({st.cnt_c, st.cnt_b} == {st.per_c, st.per_b});
  assign a_event = tgl_sync ^ st.tgl_seen;
  // Priority zero never interrupts; enabled and higher than cpu wakes
  assign wake_ok = st.ie_a & (st.prio_a != tprt_pkg::PRIO_NONE)
    & (st.prio_a > cpu_prio);

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    next_st = st;
    next_st.trig = 1'b0;
    next_st.tgl_seen = tgl_sync;
    next_st.clk_b_q = pin_b_s;
    next_st.clk_c_q = pin_c_s;
    next_st.rdata = 32'h00000000;
    // Take the counter copy once the pin side has answered, then ask again
    if (ack_s == st.snap_req)
    begin
      next_st.cnt_a = snap_a;
      next_st.snap_req = ~st.snap_req;
    end
    // Pair or single counting; trigger on a single-mode timer b match or a 32-bit pair match, not on a single timer c match
    if (run_b & tick_b)
    begin
      if (pair)
      begin
        if (match32)
        begin
          next_st.cnt_b = 16'h0000;
          next_st.cnt_c = 16'h0000;
          next_st.trig = 1'b1;
          next_st.if_b = 1'b1;
        end
        else
          {next_st.cnt_c, next_st.cnt_b} = {st.cnt_c, st.cnt_b} + 32'h00000001;
      end
      else if (match16)
      begin
        next_st.cnt_b = 16'h0000;
        next_st.trig = 1'b1;
        next_st.if_b = 1'b1;
      end
      else
        next_st.cnt_b = st.cnt_b + 16'h0001;
    end
    if (~pair & run_b & tick_c)
      next_st.cnt_c = (st.cnt_c == st.per_c) ? 16'h0000 : st.cnt_c + 16'h0001;
    // Register writes
    if (wr)
    begin
      case (addr)
        tprt_pkg::A_CTL_A: next_st.ctl_a = wdata[15:0];
        tprt_pkg::A_PER_A: next_st.per_a = wdata[15:0];
        tprt_pkg::A_CTL_B: next_st.ctl_b = wdata[15:0];
        tprt_pkg::A_CNT_B: next_st.cnt_b = wdata[15:0];
        tprt_pkg::A_PER_B: next_st.per_b = wdata[15:0];
        tprt_pkg::A_CNT_C: next_st.cnt_c = wdata[15:0];
        tprt_pkg::A_PER_C: next_st.per_c = wdata[15:0];
        tprt_pkg::A_IRQ:
        begin
          next_st.prio_a = wdata[2:0];
          next_st.ie_a = wdata[3];
          next_st.tb = wdata[9:8];
          if (wdata[4])
          begin
            next_st.if_a = 1'b0;
            next_st.wake = 1'b0;
            next_st.idle_req = 1'b0;
          end
          if (wdata[5])
            next_st.if_b = 1'b0;
        end
        default: next_st.rdata = 32'h00000000;
      endcase
    end
    // Async match sets flag; set wins over a same-cycle clear
    if (a_event)
    begin
      next_st.if_a = 1'b1;
      if (in_sleep & wake_ok)
        next_st.wake = 1'b1;
      else if (in_sleep)
        next_st.idle_req = 1'b1;
    end
    // Register reads, data in the following cycle
    if (rd)
    begin
      case (addr)
        tprt_pkg::A_CTL_A: next_st.rdata = {16'h0000, st.ctl_a};
        tprt_pkg::A_CNT_A: next_st.rdata = {16'h0000, st.cnt_a};
        tprt_pkg::A_PER_A: next_st.rdata = {16'h0000, st.per_a};
        tprt_pkg::A_CTL_B: next_st.rdata = {16'h0000, st.ctl_b};
        tprt_pkg::A_CNT_B: next_st.rdata = {16'h0000, st.cnt_b};
        tprt_pkg::A_PER_B: next_st.rdata = {16'h0000, st.per_b};
        tprt_pkg::A_CNT_C: next_st.rdata = {16'h0000, st.cnt_c};
        tprt_pkg::A_PER_C: next_st.rdata = {16'h0000, st.per_c};
        tprt_pkg::A_IRQ: next_st.rdata = {22'h000000, st.tb, 2'h0, st.if_b, st.if_a,
          st.ie_a, st.prio_a};
        tprt_pkg::A_STAT: next_st.rdata = {29'h00000000, st.idle_req, st.wake, async_run};
        default: next_st.rdata = 32'h00000000;
      endcase
    end
  end

  // Register the whole state
  always_ff @(posedge mclk or posedge any_rst)
  begin
    if (any_rst)
    begin
      st <= '0;
      st.ctl_a <= tprt_pkg::RST_CTL;
      st.ctl_b <= tprt_pkg::RST_CTL;
      st.cnt_b <= tprt_pkg::RST_CNT;
      st.cnt_c <= tprt_pkg::RST_CNT;
      st.per_a <= tprt_pkg::RST_PER;
      st.per_b <= tprt_pkg::RST_PER;
      st.per_c <= tprt_pkg::RST_PER;
    end
    else
      st <= next_st;
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign rdata = st.rdata;
  assign adc_trigger = st.trig;
  assign wake_req = st.wake;
  assign enter_idle = st.idle_req;
  assign irq = st.if_a & wake_ok;
  assign tb_sel = st.tb;
  // Time base chosen by select: single b, single c, or pair
  always_comb
  begin
    case (st.tb)
      2'h0: time_base = {16'h0000, st.cnt_b};
      2'h1: time_base = {16'h0000, st.cnt_c};
      default: time_base = pair ? {st.cnt_c, st.cnt_b} : {16'h0000, st.cnt_b};
    endcase
  end
  // Pin claimed only for external clock or internal gated mode
  assign pin_claim[0] = st.ctl_a[tprt_pkg::CTL_ON] & (st.ctl_a[tprt_pkg::CTL_SRC_SEL]
    | st.ctl_a[tprt_pkg::CTL_GATE]);
  assign pin_claim[1] = st.ctl_b[tprt_pkg::CTL_ON] & (st.ctl_b[tprt_pkg::CTL_SRC_SEL]
    | st.ctl_b[tprt_pkg::CTL_GATE]);
  assign pin_claim[2] = pin_claim[1] & pair;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_trig_pulse;
    @(posedge mclk) disable iff (any_rst) adc_trigger |=> !adc_trigger;
  endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger wider than one cycle");

  property p_trig_16;
    @(posedge mclk) disable iff (any_rst)
      (run_b && tick_b && !pair && match16 && !wr) |=> adc_trigger && st.cnt_b == 16'h0000;
  endproperty
  a_trig_16: assert property (p_trig_16) else $error("no trigger on 16-bit match");

  property p_trig_32;
    @(posedge mclk) disable iff (any_rst)
      (run_b && tick_b && pair && match32 && !wr) |=> adc_trigger;
  endproperty
  a_trig_32: assert property (p_trig_32) else $error("no trigger on 32-bit match");

  property p_sleep_halt;
    @(posedge mclk) disable iff (any_rst)
      (in_sleep && !wr) |=> $stable(st.cnt_b);
  endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("sync timer ran in sleep");

  property p_idle_stop;
    @(posedge mclk) disable iff (any_rst)
      (in_idle && st.ctl_b[tprt_pkg::CTL_STOP_IDLE] && !wr) |=> $stable(st.cnt_b);
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("timer ran in idle");

  property p_wake_hold;
    @(posedge mclk) disable iff (any_rst)
      (wake_req && !(wr && addr == tprt_pkg::A_IRQ && wdata[4])) |=> wake_req;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake request dropped");

  property p_prio_zero;
    @(posedge mclk) disable iff (any_rst)
      (st.prio_a == tprt_pkg::PRIO_NONE) |-> !irq;
  endproperty
  a_prio_zero: assert property (p_prio_zero) else $error("priority zero interrupted");

  property p_wake_cause;
    @(posedge mclk) disable iff (any_rst)
      $rose(wake_req) |-> st.if_a && $past(in_sleep);
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake without sleep match");

  property p_idle_cause;
    @(posedge mclk) disable iff (any_rst)
      (a_event && in_sleep && !wake_ok) |=> enter_idle && !wake_req;
  endproperty
  a_idle_cause: assert property (p_idle_cause) else $error("idle not requested");

  property p_pin_free;
    @(posedge mclk) disable iff (any_rst)
      (!st.ctl_b[tprt_pkg::CTL_SRC_SEL] && !st.ctl_b[tprt_pkg::CTL_GATE]) |-> !pin_claim[1];
  endproperty
  a_pin_free: assert property (p_pin_free) else $error("pin claimed when free");
endmodule

// ---- dv/tprt_power_model.sv ----
// Partner model: power controller beside the timer block, counts triggers
// Assumes: the bench picks the wanted power state; mclk and rst from the bench
`timescale 1ns/1ns
module tprt_power_model
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] want,
  input wire logic wake_req,
  input wire logic enter_idle,
  input wire logic adc_trigger,
  output logic [1:0] pwr_state,
  output int trig_seen
);
  // ************************************************************
  // Power state follows requests, wake and idle entry
  // ************************************************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pwr_state <= tprt_pkg::PWR_RUN;
      trig_seen <= 0;
    end
    else
    begin
      if (wake_req)
        pwr_state <= tprt_pkg::PWR_RUN;
      else if (enter_idle && want == tprt_pkg::PWR_SLEEP)
        pwr_state <= tprt_pkg::PWR_IDLE;
      else
        pwr_state <= want;
      // Converter side counts every trigger pulse it sees
      if (adc_trigger)
        trig_seen <= trig_seen + 1;
    end
  end
endmodule

// ---- dv/tprt_top_tb.sv ----
// Testbench: timer power, reset, trigger and pin claim checks
// Assumes: tprt_pkg compiled first; power model stands at the far side
`timescale 1ns/1ns
module tprt_top_tb;
  logic mclk = 1'b0;
  logic ext_clk = 1'b0;
  logic ext_en = 1'b0;
  logic rst = 1'b1;
  logic por_rst = 1'b0;
  logic wdt_rst = 1'b0;
  logic [2:0] cpu_prio = 3'h0;
  logic pin_b_in = 1'b0;
  logic pin_c_in = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [1:0] want = 2'h0;
  logic [31:0] rdata, time_base, rv;
  logic [1:0] tb_sel, pwr_state;
  logic adc_trigger, wake_req, enter_idle, irq;
  logic [2:0] pin_claim;
  int trig_seen;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  // ************************************************************
  // Clocks, instances and timeout
  // ************************************************************
  always #10 mclk = ~mclk;
  // Pin clock stands still low while disabled
  always #6 ext_clk = ext_en ? ~ext_clk : 1'b0;
  tprt_top dut (.mclk(mclk), .rst(rst), .ext_clk(ext_clk), .por_rst(por_rst),
    .wdt_rst(wdt_rst), .pwr_state(pwr_state), .cpu_prio(cpu_prio), .pin_b_in(pin_b_in),
    .pin_c_in(pin_c_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .tb_sel(tb_sel), .time_base(time_base), .adc_trigger(adc_trigger),
    .wake_req(wake_req), .enter_idle(enter_idle), .irq(irq), .pin_claim(pin_claim));
  tprt_power_model pwr (.mclk(mclk), .rst(rst), .want(want), .wake_req(wake_req),
    .enter_idle(enter_idle), .adc_trigger(adc_trigger), .pwr_state(pwr_state),
    .trig_seen(trig_seen));
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      test_done();
    end
  end
  // Compare, bus and wait helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [5:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic wait_trig(output int n);
    n = 0;
    do
    begin
      @(posedge mclk);
      #1 n++;
    end
    while (adc_trigger !== 1'b1 && n < 200);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  // Each reset source restores period and control values
  task automatic t_reset();
    for (int k = 0; k < 3; k++)
    begin
      wr_reg(tprt_pkg::A_PER_B, 32'h1234);
      wr_reg(tprt_pkg::A_CTL_B, 32'h8000);
      @(posedge mclk);
      if (k == 0) rst <= 1'b1;
      else if (k == 1) por_rst <= 1'b1;
      else wdt_rst <= 1'b1;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      por_rst <= 1'b0;
      wdt_rst <= 1'b0;
      rd_reg(tprt_pkg::A_PER_B);
      chk("per_b", {16'h0, tprt_pkg::RST_PER}, rv);
      rd_reg(tprt_pkg::A_CTL_B);
      chk("ctl_b", {16'h0, tprt_pkg::RST_CTL}, rv);
    end
  endtask
  // Trigger is one cycle long and repeats every period plus one
  task automatic t_trig(input logic [31:0] ctl, input logic [15:0] per);
    int n;
    wr_reg(tprt_pkg::A_PER_C, 32'h0);
    wr_reg(tprt_pkg::A_CNT_C, 32'h0);
    wr_reg(tprt_pkg::A_PER_B, {16'h0, per});
    wr_reg(tprt_pkg::A_CTL_B, ctl);
    wait_trig(n);
    @(posedge mclk);
    #1 chk("trigger width", 32'h0, {31'h0, adc_trigger});
    wait_trig(n);
    chk("trigger gap", {16'h0, per}, n);
  endtask
  // Time base select and pin claim per mode
  task automatic t_sel_pins();
    logic [31:0] ctl [5] = '{32'h8000, 32'h8080, 32'h8002, 32'h800A, 32'h0000};
    logic [2:0] exp [5] = '{3'h0, 3'h2, 3'h2, 3'h6, 3'h0};
    logic [31:0] tbv [4] = '{32'h00001234, 32'h00005678, 32'h56781234, 32'h56781234};
    // Counts parked with the pair selected and the timer off
    wr_reg(tprt_pkg::A_CTL_B, 32'h0008);
    wr_reg(tprt_pkg::A_CNT_B, 32'h1234);
    wr_reg(tprt_pkg::A_CNT_C, 32'h5678);
    for (int k = 0; k < 4; k++)
    begin
      wr_reg(tprt_pkg::A_IRQ, 32'(k) << 8);
      @(posedge mclk);
      #1 chk("tb_sel", k, {30'h0, tb_sel});
      chk("time_base", tbv[k], time_base);
    end
    wr_reg(tprt_pkg::A_CTL_B, 32'h0000);
    @(posedge mclk);
    #1 chk("time_base single", 32'h00001234, time_base);
    for (int k = 0; k < 5; k++)
    begin
      wr_reg(tprt_pkg::A_CTL_B, ctl[k]);
      @(posedge mclk);
      #1 chk("pin_claim", {29'h0, exp[k]}, {29'h0, pin_claim});
    end
  endtask
  // Counter moves or stands in the given power state
  task automatic t_halt(input logic [5:0] ca, input logic [31:0] ctl, input logic [1:0] st,
    input logic moving);
    logic [31:0] a;
    @(posedge mclk);
    want <= st;
    ext_en = 1'b1;
    wr_reg(ca + 6'h04, 32'hFFFF);
    wr_reg(ca - 6'h04, ctl);
    repeat (4) @(posedge mclk);
    rd_reg(ca);
    a = rv;
    repeat (20) @(posedge mclk);
    rd_reg(ca);
    chk("count moving", {31'h0, moving}, {31'h0, a !== rv});
    wr_reg(ca - 6'h04, 32'h0);
    ext_en = 1'b0;
    want <= tprt_pkg::PWR_RUN;
  endtask
  // Async match in sleep: wake or idle by priority
  task automatic t_async(input logic [31:0] iv, input logic [2:0] cpu, input logic ew,
    input logic ei);
    int n;
    // Pin-side counter restarts from zero so the short period matches soon
    @(posedge mclk);
    por_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    por_rst <= 1'b0;
    want <= tprt_pkg::PWR_SLEEP;
    cpu_prio <= cpu;
    wr_reg(tprt_pkg::A_IRQ, iv);
    wr_reg(tprt_pkg::A_PER_A, 32'h3);
    wr_reg(tprt_pkg::A_CTL_A, 32'h8002);
    ext_en = 1'b1;
    n = 0;
    while (wake_req !== 1'b1 && enter_idle !== 1'b1 && n < 200)
    begin
      @(posedge mclk);
      #1 n++;
    end
    ext_en = 1'b0;
    repeat (10) @(posedge mclk);
    #1 chk("wake_req", ew, wake_req);
    chk("enter_idle", ei, enter_idle);
    chk("irq", ew, irq);
    chk("pin_claim a", 32'h1, {31'h0, pin_claim[0]});
    rd_reg(tprt_pkg::A_IRQ);
    chk("flag", 32'h1, rv[4]);
    wr_reg(tprt_pkg::A_IRQ, iv | 32'h10);
    @(posedge mclk);
    #1 chk("wake cleared", 32'h0, {30'h0, wake_req, enter_idle});
    wr_reg(tprt_pkg::A_CTL_A, 32'h0);
    want <= tprt_pkg::PWR_RUN;
  endtask
  // ************************************************************
  // Main sequence and verdict
  // ************************************************************
  task automatic test_done();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    pin_b_in <= 1'b1;
    t_reset();
    t_trig(32'h8000, 16'h2);
    t_trig(32'h8008, 16'h3);
    chk("triggers used", 32'h1, {31'h0, trig_seen > 2});
    t_sel_pins();
    t_halt(tprt_pkg::A_CNT_B, 32'h8000, tprt_pkg::PWR_SLEEP, 1'b0);
    t_halt(tprt_pkg::A_CNT_A, 32'h8006, tprt_pkg::PWR_SLEEP, 1'b0);
    t_halt(tprt_pkg::A_CNT_A, 32'h8002, tprt_pkg::PWR_SLEEP, 1'b1);
    t_halt(tprt_pkg::A_CNT_B, 32'hA000, tprt_pkg::PWR_IDLE, 1'b0);
    t_halt(tprt_pkg::A_CNT_B, 32'h8000, tprt_pkg::PWR_IDLE, 1'b1);
    t_halt(tprt_pkg::A_CNT_B, 32'h8080, tprt_pkg::PWR_RUN, 1'b1);
    pin_b_in <= 1'b0;
    t_halt(tprt_pkg::A_CNT_B, 32'h8080, tprt_pkg::PWR_RUN, 1'b0);
    pin_b_in <= 1'b1;
    t_async(32'h0D, 3'h2, 1'b1, 1'b0);
    t_async(32'h0A, 3'h2, 1'b0, 1'b1);
    t_async(32'h08, 3'h0, 1'b0, 1'b1);
    test_done();
  end
endmodule
